// ### src/ivp_consts.vh
// Purpose: constants for the interrupt vector priority block
// Assumes: 16-bit cpu address space, vectors at top of memory
// Notes: source index 0 is lowest rank; index rises with vector address
`ifndef IVP_CONSTS_VH
`define IVP_CONSTS_VH

`define IVP_VEC_LO 16'hFFCC
`define IVP_VEC_HI 16'hFFFF
`define IVP_NUM_SRC 26
`define IVP_SRC_W 5

`define IVP_LOW_BYTE 16'h0001
`define IVP_RST_ADDR 16'h0000

`define IVP_VEC_TIMER_A_CH5 16'hFFCC
`define IVP_VEC_TIMER_A_CH4 16'hFFCE
`define IVP_VEC_CONV 16'hFFD0
`define IVP_VEC_KBD 16'hFFD2
`define IVP_VEC_ASP_TX 16'hFFD4
`define IVP_VEC_ASP_RX 16'hFFD6
`define IVP_VEC_ASP_ERR 16'hFFD8
`define IVP_VEC_CAN_TX 16'hFFDA
`define IVP_VEC_CAN_RX 16'hFFDC
`define IVP_VEC_CAN_ERR 16'hFFDE
`define IVP_VEC_CAN_WAKE 16'hFFE0
`define IVP_VEC_SPI_TX 16'hFFE2
`define IVP_VEC_SPI_RX 16'hFFE4
`define IVP_VEC_TIMER_B_OVF 16'hFFE6
`define IVP_VEC_TIMER_B_CH1 16'hFFE8
`define IVP_VEC_TIMER_B_CH0 16'hFFEA
`define IVP_VEC_TIMER_A_OVF 16'hFFEC
`define IVP_VEC_TIMER_A_CH3 16'hFFEE
`define IVP_VEC_TIMER_A_CH2 16'hFFF0
`define IVP_VEC_TIMER_A_CH1 16'hFFF2
`define IVP_VEC_TIMER_A_CH0 16'hFFF4
`define IVP_VEC_PERIODIC 16'hFFF6
`define IVP_VEC_PLL 16'hFFF8
`define IVP_VEC_EXT_PIN 16'hFFFA
`define IVP_VEC_SOFT_INT 16'hFFFC
`define IVP_VEC_RESET 16'hFFFE

`endif

// ### src/ivp_vector_priority.v
// Purpose: rank pending interrupt sources, present winning vector location
// Assumes: inputs synchronous to clk; cpu holds ack low until it fetches
// Notes: outputs registered; one cycle from pending change to new vector while no request is held, else the vector waits for ack
`timescale 1ns/1ps
`include "ivp_consts.vh"

module ivp_vector_priority (
   // clock and reset
   input wire clk,
   input wire reset,
   // sources, bit index = rank, bit 25 is reset request
   input wire [25:0] src_pending,
   input wire [25:0] src_enable,
   // cpu side
   input wire vec_ack,
   output reg irq_req_r,
   output reg [4:0] vec_src_r,
   output reg [15:0] vec_addr_hi_r,
   output reg [15:0] vec_addr_lo_r,
   // lookup of a byte address inside the vector region
   input wire [15:0] probe_addr,
   output reg probe_in_region_r,
   output reg probe_is_low_r,
   output reg [4:0] probe_src_r
);

   // source ranks, lowest first; rank order is the priority order
   localparam [4:0] RK_TIMER_A_CH5 = 5'h00;
   localparam [4:0] RK_TIMER_A_CH4 = 5'h01;
   localparam [4:0] RK_CONVERTER = 5'h02;
   localparam [4:0] RK_KEYBOARD = 5'h03;
   localparam [4:0] RK_ASP_TX = 5'h04;
   localparam [4:0] RK_ASP_RX = 5'h05;
   localparam [4:0] RK_ASP_ERR = 5'h06;
   localparam [4:0] RK_CAN_TX = 5'h07;
   localparam [4:0] RK_CAN_RX = 5'h08;
   localparam [4:0] RK_CAN_ERR = 5'h09;
   localparam [4:0] RK_CAN_WAKE = 5'h0A;
   localparam [4:0] RK_SPI_TX = 5'h0B;
   localparam [4:0] RK_SPI_RX = 5'h0C;
   localparam [4:0] RK_TIMER_B_OVF = 5'h0D;
   localparam [4:0] RK_TIMER_B_CH1 = 5'h0E;
   localparam [4:0] RK_TIMER_B_CH0 = 5'h0F;
   localparam [4:0] RK_TIMER_A_OVF = 5'h10;
   localparam [4:0] RK_TIMER_A_CH3 = 5'h11;
   localparam [4:0] RK_TIMER_A_CH2 = 5'h12;
   localparam [4:0] RK_TIMER_A_CH1 = 5'h13;
   localparam [4:0] RK_TIMER_A_CH0 = 5'h14;
   localparam [4:0] RK_PERIODIC = 5'h15;
   localparam [4:0] RK_PLL = 5'h16;
   localparam [4:0] RK_EXT_PIN = 5'h17;
   localparam [4:0] RK_SOFT_INT = 5'h18;
   localparam [4:0] RK_RESET = 5'h19;

   // vector high-byte address for each source rank
   function [15:0] ivp_vec_addr;
      input [4:0] idx;
      begin
         case (idx)
            RK_TIMER_A_CH5: ivp_vec_addr = `IVP_VEC_TIMER_A_CH5;
            RK_TIMER_A_CH4: ivp_vec_addr = `IVP_VEC_TIMER_A_CH4;
            RK_CONVERTER: ivp_vec_addr = `IVP_VEC_CONV;
            RK_KEYBOARD: ivp_vec_addr = `IVP_VEC_KBD;
            RK_ASP_TX: ivp_vec_addr = `IVP_VEC_ASP_TX;
            RK_ASP_RX: ivp_vec_addr = `IVP_VEC_ASP_RX;
            RK_ASP_ERR: ivp_vec_addr = `IVP_VEC_ASP_ERR;
            RK_CAN_TX: ivp_vec_addr = `IVP_VEC_CAN_TX;
            RK_CAN_RX: ivp_vec_addr = `IVP_VEC_CAN_RX;
            RK_CAN_ERR: ivp_vec_addr = `IVP_VEC_CAN_ERR;
            RK_CAN_WAKE: ivp_vec_addr = `IVP_VEC_CAN_WAKE;
            RK_SPI_TX: ivp_vec_addr = `IVP_VEC_SPI_TX;
            RK_SPI_RX: ivp_vec_addr = `IVP_VEC_SPI_RX;
            RK_TIMER_B_OVF: ivp_vec_addr = `IVP_VEC_TIMER_B_OVF;
            RK_TIMER_B_CH1: ivp_vec_addr = `IVP_VEC_TIMER_B_CH1;
            RK_TIMER_B_CH0: ivp_vec_addr = `IVP_VEC_TIMER_B_CH0;
            RK_TIMER_A_OVF: ivp_vec_addr = `IVP_VEC_TIMER_A_OVF;
            RK_TIMER_A_CH3: ivp_vec_addr = `IVP_VEC_TIMER_A_CH3;
            RK_TIMER_A_CH2: ivp_vec_addr = `IVP_VEC_TIMER_A_CH2;
            RK_TIMER_A_CH1: ivp_vec_addr = `IVP_VEC_TIMER_A_CH1;
            RK_TIMER_A_CH0: ivp_vec_addr = `IVP_VEC_TIMER_A_CH0;
            RK_PERIODIC: ivp_vec_addr = `IVP_VEC_PERIODIC;
            RK_PLL: ivp_vec_addr = `IVP_VEC_PLL;
            RK_EXT_PIN: ivp_vec_addr = `IVP_VEC_EXT_PIN;
            RK_SOFT_INT: ivp_vec_addr = `IVP_VEC_SOFT_INT;
            default: ivp_vec_addr = `IVP_VEC_RESET;
         endcase
      end
   endfunction

   // low-byte address sits one above the even high-byte address
   function [15:0] ivp_vec_low;
      input [15:0] hi_addr;
      begin
         ivp_vec_low = hi_addr | `IVP_LOW_BYTE;
      end
   endfunction

   // rank owning a byte address; anything below the region reads 0
   function [4:0] ivp_rank_of;
      input [15:0] addr;
      reg [15:0] ev;
      begin
         ev = {addr[15:1], 1'b0};
         if (addr < `IVP_VEC_LO) ivp_rank_of = 5'h00;
         else if (ev == `IVP_VEC_TIMER_A_CH5) ivp_rank_of = RK_TIMER_A_CH5;
         else if (ev == `IVP_VEC_TIMER_A_CH4) ivp_rank_of = RK_TIMER_A_CH4;
         else if (ev == `IVP_VEC_CONV) ivp_rank_of = RK_CONVERTER;
         else if (ev == `IVP_VEC_KBD) ivp_rank_of = RK_KEYBOARD;
         else if (ev == `IVP_VEC_ASP_TX) ivp_rank_of = RK_ASP_TX;
         else if (ev == `IVP_VEC_ASP_RX) ivp_rank_of = RK_ASP_RX;
         else if (ev == `IVP_VEC_ASP_ERR) ivp_rank_of = RK_ASP_ERR;
         else if (ev == `IVP_VEC_CAN_TX) ivp_rank_of = RK_CAN_TX;
         else if (ev == `IVP_VEC_CAN_RX) ivp_rank_of = RK_CAN_RX;
         else if (ev == `IVP_VEC_CAN_ERR) ivp_rank_of = RK_CAN_ERR;
         else if (ev == `IVP_VEC_CAN_WAKE) ivp_rank_of = RK_CAN_WAKE;
         else if (ev == `IVP_VEC_SPI_TX) ivp_rank_of = RK_SPI_TX;
         else if (ev == `IVP_VEC_SPI_RX) ivp_rank_of = RK_SPI_RX;
         else if (ev == `IVP_VEC_TIMER_B_OVF) ivp_rank_of = RK_TIMER_B_OVF;
         else if (ev == `IVP_VEC_TIMER_B_CH1) ivp_rank_of = RK_TIMER_B_CH1;
         else if (ev == `IVP_VEC_TIMER_B_CH0) ivp_rank_of = RK_TIMER_B_CH0;
         else if (ev == `IVP_VEC_TIMER_A_OVF) ivp_rank_of = RK_TIMER_A_OVF;
         else if (ev == `IVP_VEC_TIMER_A_CH3) ivp_rank_of = RK_TIMER_A_CH3;
         else if (ev == `IVP_VEC_TIMER_A_CH2) ivp_rank_of = RK_TIMER_A_CH2;
         else if (ev == `IVP_VEC_TIMER_A_CH1) ivp_rank_of = RK_TIMER_A_CH1;
         else if (ev == `IVP_VEC_TIMER_A_CH0) ivp_rank_of = RK_TIMER_A_CH0;
         else if (ev == `IVP_VEC_PERIODIC) ivp_rank_of = RK_PERIODIC;
         else if (ev == `IVP_VEC_PLL) ivp_rank_of = RK_PLL;
         else if (ev == `IVP_VEC_EXT_PIN) ivp_rank_of = RK_EXT_PIN;
         else if (ev == `IVP_VEC_SOFT_INT) ivp_rank_of = RK_SOFT_INT;
         else ivp_rank_of = RK_RESET;
      end
   endfunction

   // gated pending set; reset request cannot be masked
   wire [25:0] active;
   assign active = src_pending & {1'b1, src_enable[24:0]};

   // one name per gated source, lowest rank first
   wire req_timer_a_ch5 = active[RK_TIMER_A_CH5];
   wire req_timer_a_ch4 = active[RK_TIMER_A_CH4];
   wire req_converter = active[RK_CONVERTER];
   wire req_keyboard = active[RK_KEYBOARD];
   wire req_asp_tx = active[RK_ASP_TX];
   wire req_asp_rx = active[RK_ASP_RX];
   wire req_asp_err = active[RK_ASP_ERR];
   wire req_can_tx = active[RK_CAN_TX];
   wire req_can_rx = active[RK_CAN_RX];
   wire req_can_err = active[RK_CAN_ERR];
   wire req_can_wake = active[RK_CAN_WAKE];
   wire req_spi_tx = active[RK_SPI_TX];
   wire req_spi_rx = active[RK_SPI_RX];
   wire req_timer_b_ovf = active[RK_TIMER_B_OVF];
   wire req_timer_b_ch1 = active[RK_TIMER_B_CH1];
   wire req_timer_b_ch0 = active[RK_TIMER_B_CH0];
   wire req_timer_a_ovf = active[RK_TIMER_A_OVF];
   wire req_timer_a_ch3 = active[RK_TIMER_A_CH3];
   wire req_timer_a_ch2 = active[RK_TIMER_A_CH2];
   wire req_timer_a_ch1 = active[RK_TIMER_A_CH1];
   wire req_timer_a_ch0 = active[RK_TIMER_A_CH0];
   wire req_periodic = active[RK_PERIODIC];
   wire req_pll = active[RK_PLL];
   wire req_ext_pin = active[RK_EXT_PIN];
   wire req_soft_int = active[RK_SOFT_INT];
   wire req_reset = active[RK_RESET];

   // priority chain from the top rank down; first hit wins
   reg [4:0] win_idx;
   reg win_any;
   always @* begin
      win_any = |active;
      win_idx = RK_TIMER_A_CH5;
      if (req_reset) begin
         win_idx = RK_RESET;
      end else if (req_soft_int) begin
         win_idx = RK_SOFT_INT;
      end else if (req_ext_pin) begin
         win_idx = RK_EXT_PIN;
      end else if (req_pll) begin
         win_idx = RK_PLL;
      end else if (req_periodic) begin
         win_idx = RK_PERIODIC;
      end else if (req_timer_a_ch0) begin
         win_idx = RK_TIMER_A_CH0;
      end else if (req_timer_a_ch1) begin
         win_idx = RK_TIMER_A_CH1;
      end else if (req_timer_a_ch2) begin
         win_idx = RK_TIMER_A_CH2;
      end else if (req_timer_a_ch3) begin
         win_idx = RK_TIMER_A_CH3;
      end else if (req_timer_a_ovf) begin
         win_idx = RK_TIMER_A_OVF;
      end else if (req_timer_b_ch0) begin
         win_idx = RK_TIMER_B_CH0;
      end else if (req_timer_b_ch1) begin
         win_idx = RK_TIMER_B_CH1;
      end else if (req_timer_b_ovf) begin
         win_idx = RK_TIMER_B_OVF;
      end else if (req_spi_rx) begin
         win_idx = RK_SPI_RX;
      end else if (req_spi_tx) begin
         win_idx = RK_SPI_TX;
      end else if (req_can_wake) begin
         win_idx = RK_CAN_WAKE;
      end else if (req_can_err) begin
         win_idx = RK_CAN_ERR;
      end else if (req_can_rx) begin
         win_idx = RK_CAN_RX;
      end else if (req_can_tx) begin
         win_idx = RK_CAN_TX;
      end else if (req_asp_err) begin
         win_idx = RK_ASP_ERR;
      end else if (req_asp_rx) begin
         win_idx = RK_ASP_RX;
      end else if (req_asp_tx) begin
         win_idx = RK_ASP_TX;
      end else if (req_keyboard) begin
         win_idx = RK_KEYBOARD;
      end else if (req_converter) begin
         win_idx = RK_CONVERTER;
      end else if (req_timer_a_ch4) begin
         win_idx = RK_TIMER_A_CH4;
      end
   end

   // probe address falls inside the vector region
   wire probe_hit;
   assign probe_hit = (probe_addr >= `IVP_VEC_LO);

   // next vector group; a held vector only moves once the cpu acks
   reg irq_req_nxt;
   reg [4:0] vec_src_nxt;
   reg [15:0] vec_addr_hi_nxt;
   reg [15:0] vec_addr_lo_nxt;
   always @* begin
      irq_req_nxt = irq_req_r;
      vec_src_nxt = vec_src_r;
      vec_addr_hi_nxt = vec_addr_hi_r;
      vec_addr_lo_nxt = vec_addr_lo_r;
      if (!irq_req_r || vec_ack) begin
         irq_req_nxt = win_any;
         vec_src_nxt = win_idx;
         vec_addr_hi_nxt = ivp_vec_addr(win_idx);
         vec_addr_lo_nxt = ivp_vec_low(ivp_vec_addr(win_idx));
      end
   end

   // vector group flops
   always @(posedge clk) begin
      if (reset) begin
         irq_req_r <= 1'b0;
         vec_src_r <= 5'h00;
         vec_addr_hi_r <= `IVP_RST_ADDR;
         vec_addr_lo_r <= `IVP_RST_ADDR;
      end else begin
         irq_req_r <= irq_req_nxt;
         vec_src_r <= vec_src_nxt;
         vec_addr_hi_r <= vec_addr_hi_nxt;
         vec_addr_lo_r <= vec_addr_lo_nxt;
      end
   end

   // next probe result; below the region everything reads zero
   reg probe_in_region_nxt;
   reg probe_is_low_nxt;
   reg [4:0] probe_src_nxt;
   always @* begin
      probe_in_region_nxt = probe_hit;
      probe_is_low_nxt = probe_hit & probe_addr[0];
      probe_src_nxt = ivp_rank_of(probe_addr);
   end

   // probe result flops
   always @(posedge clk) begin
      if (reset) begin
         probe_in_region_r <= 1'b0;
         probe_is_low_r <= 1'b0;
         probe_src_r <= 5'h00;
      end else begin
         probe_in_region_r <= probe_in_region_nxt;
         probe_is_low_r <= probe_is_low_nxt;
         probe_src_r <= probe_src_nxt;
      end
   end

endmodule // ivp_vector_priority

// ### test/ivp_cpu_model.sv
// Purpose: cpu core stand-in that fetches vectors
// Assumes: ack is a one-cycle pulse per fetch
// Notes: lat sets how long the core waits
`timescale 1ns/1ps
module ivp_cpu_model (
   // clock, block outputs, pace
   input wire clk, input wire reset, input wire irq,
   input wire [15:0] hi, input wire [15:0] lo, input wire [3:0] lat,
   // fetch pulse and fetched pair
   output reg ack, output reg [31:0] got);
   reg [3:0] cnt;
   // wait lat cycles, take both bytes, pulse ack
   always @(posedge clk) begin
      ack <= 1'b0;
      if (reset) cnt <= 4'h0;
      else if (irq && !ack) begin
         cnt <= cnt + 4'h1;
         if (cnt == lat) begin
            ack <= 1'b1;
            got <= {hi, lo};
            cnt <= 4'h0;
         end
      end
   end
endmodule // ivp_cpu_model

// ### test/ivp_vector_priority_properties.sv
// Purpose: port checks for the vector priority block
// Assumes: one clock, sync active-high reset
// Notes: bound after the module
`timescale 1ns/1ps
module ivp_vector_priority_properties (
   // all ports of the block
   input wire clk, input wire reset, input wire vec_ack,
   input wire [25:0] src_pending, input wire [25:0] src_enable,
   input wire irq_req_r, input wire [4:0] vec_src_r,
   input wire [15:0] vec_addr_hi_r, input wire [15:0] vec_addr_lo_r,
   input wire [15:0] probe_addr, input wire probe_in_region_r,
   input wire probe_is_low_r, input wire [4:0] probe_src_r);
   // enabled pending set and the cycles that may load a new vector
   wire [25:0] eff = src_pending & {1'b1, src_enable[24:0]};
   wire new_v = (!irq_req_r || vec_ack) && !reset;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_lo_pair:
   assert property (irq_req_r |-> vec_addr_lo_r == (vec_addr_hi_r | 16'h0001))
      else $error("low byte not beside high byte");
   chk_vec_map:
   assert property (irq_req_r |-> vec_addr_hi_r == 16'hFFCC + {vec_src_r, 1'b0})
      else $error("vector location wrong");
   chk_req_cause:
   assert property ($past(new_v) |-> irq_req_r == |$past(eff))
      else $error("request not tied to pending");
   chk_win_rank:
   assert property ($past(new_v) && irq_req_r |-> ($past(eff) >> vec_src_r) == 26'h1)
      else $error("winner not highest pending");
   chk_hold_vec:
   assert property (irq_req_r && !vec_ack |=> irq_req_r && $stable(vec_addr_hi_r))
      else $error("vector moved before ack");
   chk_probe_in:
   assert property (!$past(reset) |-> probe_in_region_r == ($past(probe_addr) >= 16'hFFCC))
      else $error("region flag wrong");
   chk_probe_src:
   assert property (!$past(reset) && probe_in_region_r |->
      {probe_src_r, probe_is_low_r} == $past(probe_addr[5:0]) - 6'h0C)
      else $error("probe rank wrong");
   chk_probe_out:
   assert property (!probe_in_region_r |-> !probe_is_low_r && probe_src_r == 5'h00)
      else $error("probe outside region flagged");
endmodule // ivp_vector_priority_properties
bind ivp_vector_priority ivp_vector_priority_properties u_chk (.*);

// ### test/tb_interrupt_vector_priority.sv
// Purpose: drives sources and probe, checks fetched vectors
// Assumes: 200 MHz clock, sync reset
// Notes: the core model paces acknowledge
`timescale 1ns/1ps
module tb_interrupt_vector_priority;
   reg clk = 1'b0, reset = 1'b1;
   reg [25:0] pend = 26'h0, en = 26'h0;
   reg [15:0] pa = 16'h0;
   reg [3:0] lat = 4'h0;
   wire irq, ack, p_in, p_low;
   wire [4:0] src, psrc;
   wire [15:0] hi, lo;
   wire [31:0] got;
   integer miscompares = 0, n_tests = 0, i;
   always #2.5 clk = ~clk;
   ivp_vector_priority uut (.clk(clk), .reset(reset), .src_pending(pend),
      .src_enable(en), .vec_ack(ack), .irq_req_r(irq), .vec_src_r(src),
      .vec_addr_hi_r(hi), .vec_addr_lo_r(lo), .probe_addr(pa),
      .probe_in_region_r(p_in), .probe_is_low_r(p_low), .probe_src_r(psrc));
   ivp_cpu_model cpu (.clk(clk), .reset(reset), .irq(irq), .hi(hi),
      .lo(lo), .lat(lat), .ack(ack), .got(got));
   task check(input [8*5:1] nm, input [31:0] e, input [31:0] s);
      begin
         n_tests = n_tests + 1;
         if (e !== s) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, s);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // raise sources, let the core fetch, expect the pair at a
   task fetch(input [25:0] p, input [25:0] m, input [15:0] a);
      integer k;
      begin
         @(posedge clk);
         pend <= p;
         en <= m;
         for (k = 0; k < 20 && ack !== 1'b1; k = k + 1) @(posedge clk) #1;
         check("ack", 32'h1, {31'h0, ack});
         if (ack !== 1'b1) final_report;
         check("pair", {a, a | 16'h0001}, got);
         check("src", {16'h0, (a - 16'hFFCC) >> 1}, {27'h0, src});
         @(posedge clk);
         pend <= 26'h0;
         for (k = 0; k < 20 && irq !== 1'b0; k = k + 1) @(posedge clk) #1;
         check("idle", 32'h0, {31'h0, irq});
         if (irq !== 1'b0) final_report;
      end
   endtask
   task t_map;
      for (i = 0; i < 26; i = i + 1)
         fetch(26'h1 << i, 26'h3FFFFFF, 16'hFFCC + 16'h2 * i);
   endtask
   task t_rank;
      begin
         lat <= 4'h3;
         fetch(26'h30, 26'h3FFFFFF, 16'hFFD6);
         fetch(26'hC000, 26'h3FFFFFF, 16'hFFEA);
         fetch(26'h3FFFFFF, 26'h3FFFFFF, 16'hFFFE);
         fetch(26'h1FFFFFF, 26'hF, 16'hFFD2);
         fetch(26'h2000000, 26'h0, 16'hFFFE);
      end
   endtask
   task probe(input [15:0] a, input [6:0] e);
      begin
         @(posedge clk);
         pa <= a;
         @(posedge clk) #1;
         check("probe", {25'h0, e}, {25'h0, p_in, p_low, psrc});
      end
   endtask
   task t_probe;
      begin
         probe(16'hFFCB, 7'h00);
         probe(16'hFFCD, 7'h60);
         probe(16'hFFFF, 7'h79);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_map;
      t_rank;
      t_probe;
      final_report;
   end
endmodule // tb_interrupt_vector_priority
